// File: dfr_pkg.sv
// Package for the loop zero delta-frequency readback block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package dfr_pkg;

  // ==========================================================================
  // Register map
  // Some printed offsets are not word aligned, so each printed offset is an
  // index and its byte address is four times that index.
  localparam logic [11:0] RESULT_IDX0   = 12'h300;
  localparam logic [11:0] RESULT_IDX4   = 12'h304;
  localparam logic [11:0] CONTROL_IDX   = 12'h305;
  localparam logic [11:0] AUTO_CTRL_IDX = 12'h380;
  localparam logic [11:0] STATUS_IDX    = 12'h381;
  localparam int          ADDR_W        = 14;

  // ==========================================================================
  // Field layout and reset values
  localparam int         SEM_BIT       = 4;
  localparam int         SEL_MSB       = 2;
  localparam logic [7:0] CONTROL_MASK  = 8'h17;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int         DF_W          = 40;
  localparam logic [1:0] AXI_OKAY      = 2'h0;
  localparam logic [1:0] AXI_SLVERR    = 2'h2;

  // Loop states as seen by the readback logic.
  typedef enum logic [1:0] {
    LOOP_NORMAL   = 2'b00,
    LOOP_HOLDOVER = 2'b01,
    LOOP_NCO      = 2'b10
  } dfr_loop_t;

  // Live and latched loop quantities.
  typedef struct packed {
    logic [39:0] integ;
    logic [39:0] hold_filt;
    logic [39:0] pi_sum;
    logic [39:0] prop;
  } dfr_quant_t;

endpackage

// File: dfr_select.sv
// Selection of the captured loop quantity from selector and loop state.
// Assumes latched values are frozen by the parent on state entry.
`timescale 1ns/1ps
`default_nettype none

module dfr_select (
  // Selection inputs
  input  wire logic [2:0]          sel,
  input  wire dfr_pkg::dfr_loop_t  state,
  input  wire logic                nco_from_hold,
  // Quantities
  input  wire dfr_pkg::dfr_quant_t live,
  input  wire dfr_pkg::dfr_quant_t held,
  // Result
  output logic [39:0]              value
);

  // ==========================================================================
  // Quantity multiplexer
  // Picks the value per state, selector and state before NCO entry.
  always_comb begin
    value = live.hold_filt;
    case (state)
      dfr_pkg::LOOP_NORMAL: begin
        case (sel[1:0])
          2'h0:    value = live.integ;
          2'h1:    value = live.hold_filt;
          2'h2:    value = live.pi_sum;
          default: value = live.prop;
        endcase
      end
      dfr_pkg::LOOP_HOLDOVER: begin
        case (sel)
          3'h4:    value = held.integ;
          3'h6:    value = held.pi_sum;
          3'h7:    value = held.prop;
          default: value = live.hold_filt;
        endcase
      end
      dfr_pkg::LOOP_NCO: begin
        case (sel[1:0])
          2'h0: value = held.integ;
          2'h1: value = held.hold_filt;
          2'h2: begin
            if (!sel[2] && nco_from_hold) begin
              value = held.hold_filt;
            end else begin
              value = held.pi_sum;
            end
          end
          default: value = held.prop;
        endcase
      end
      default: value = live.hold_filt;
    endcase
  end

endmodule

`default_nettype wire

// File: dfr_readback.sv
// Delta-frequency readback control for loop zero, with AXI4-Lite registers.
// Assumes loop quantities and state arrive on the same clock as aclk.
//
// Contract
// - Writing one to bit 4 starts readback.
// - Store result first, then clear request bit.
// - Host writes one only; device clears.
// - Bits 2:0 select manual and auto captures.
// - Normal state: low bits pick the quantity.
// - Holdover: latched or filter output by code.
// - NCO: values frozen at NCO entry; from holdover, all but filter output keep holdover-entry values.
// - NCO code 010 depends on prior state.
// - Result is 40-bit two's complement offset.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module dfr_readback (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write address and data
  input  wire logic [13:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [13:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Loop state and quantities
  input  wire dfr_pkg::dfr_loop_t  loop_state,
  input  wire dfr_pkg::dfr_quant_t loop_quant,
  input  wire logic                nco_read_tick,
  // Delta-frequency result and control for the synthesizers
  output logic [39:0]              delta_freq_result,
  output logic                     readback_busy
);

  // ==========================================================================
  // State declarations
  typedef enum logic [1:0] {
    RB_IDLE    = 2'b00,
    RB_CAPTURE = 2'b01,
    RB_CLEAR   = 2'b10
  } dfr_rb_t;

  dfr_rb_t            rb_q, rb_d;
  logic [7:0]         ctrl_q, ctrl_d;
  logic               auto_en_q, auto_en_d;
  logic [39:0]        result_q, result_d;
  dfr_pkg::dfr_quant_t held_q, held_d;
  dfr_pkg::dfr_loop_t prev_q, prev_d;
  logic               from_hold_q, from_hold_d;
  logic               aw_q, aw_d, w_q, w_d;
  logic [11:0]        awidx_q, awidx_d;
  logic [31:0]        wdata_q, wdata_d;
  logic [3:0]         wstrb_q, wstrb_d;
  logic               bvalid_q, bvalid_d;
  logic [1:0]         bresp_q, bresp_d;
  logic               rvalid_q, rvalid_d;
  logic [31:0]        rdata_q, rdata_d;
  logic [1:0]         rresp_q, rresp_d;
  logic [39:0]        sel_value;
  logic               wr_go;
  logic               sem_wr;
  logic               awrdy_q, awrdy_d, wrdy_q, wrdy_d;
  logic               arrdy_q, arrdy_d;

  // Converts a byte address to a register index.
  function automatic logic [11:0] to_idx(input logic [13:0] a);
    return a[13:2];
  endfunction

  // Merges a strobed byte lane into an old byte.
  function automatic logic [7:0] lane(input logic [7:0] old,
                                      input logic [7:0] nw,
                                      input logic       en);
    return en ? nw : old;
  endfunction

  // ==========================================================================
  // Quantity selection
  // Selector drives both paths.
  dfr_select dfr_select_inst (
    .sel           (ctrl_q[dfr_pkg::SEL_MSB:0]),
    .state         (prev_q),
    .nco_from_hold (from_hold_q),
    .live          (loop_quant),
    .held          (held_q),
    .value         (sel_value)
  );

  assign wr_go = aw_q && w_q && !bvalid_q;

  // A host write that sets the request bit in this cycle.
  assign sem_wr = wr_go && awidx_q == dfr_pkg::CONTROL_IDX &&
                  wstrb_q[0] && wdata_q[dfr_pkg::SEM_BIT];

  // ==========================================================================
  // Loop state tracking
  // Latches all quantities on entry into holdover or NCO from normal, only the filter output on
  // NCO entry from holdover, and records the state that NCO was entered from.
  always_comb begin
    held_d      = held_q;
    from_hold_d = from_hold_q;
    prev_d      = loop_state;
    if (loop_state != prev_q) begin
      if (loop_state == dfr_pkg::LOOP_HOLDOVER &&
          prev_q == dfr_pkg::LOOP_NORMAL) begin
        held_d = loop_quant;
      end else if (loop_state == dfr_pkg::LOOP_NCO) begin
        if (prev_q == dfr_pkg::LOOP_NORMAL) begin
          held_d = loop_quant;
        end else begin
          held_d.hold_filt = loop_quant.hold_filt;
        end
        from_hold_d = (prev_q == dfr_pkg::LOOP_HOLDOVER);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_q      <= '0;
      from_hold_q <= 1'b0;
      prev_q      <= dfr_pkg::LOOP_NORMAL;
    end else begin
      held_q      <= held_d;
      from_hold_q <= from_hold_d;
      prev_q      <= prev_d;
    end
  end

  // ==========================================================================
  // Readback sequencer and register contents
  // A request spends one cycle capturing and one clearing, so the result
  // is already stored when software sees the request bit drop.
  always_comb begin
    rb_d      = rb_q;
    ctrl_d    = ctrl_q;
    auto_en_d = auto_en_q;
    result_d  = result_q;
    if (wr_go) begin
      if (awidx_q == dfr_pkg::CONTROL_IDX && wstrb_q[0]) begin
        ctrl_d[dfr_pkg::SEL_MSB:0] = wdata_q[dfr_pkg::SEL_MSB:0];
        if (wdata_q[dfr_pkg::SEM_BIT]) begin
          ctrl_d[dfr_pkg::SEM_BIT] = 1'b1;
        end
      end
      if (awidx_q == dfr_pkg::AUTO_CTRL_IDX && wstrb_q[0]) begin
        auto_en_d = wdata_q[0];
      end
      if (awidx_q >= dfr_pkg::RESULT_IDX0 &&
          awidx_q <= dfr_pkg::RESULT_IDX4 && wstrb_q[0]) begin
        case (awidx_q[2:0])
          3'h0:    result_d[7:0]   = lane(result_q[7:0],   wdata_q[7:0], 1'b1);
          3'h1:    result_d[15:8]  = lane(result_q[15:8],  wdata_q[7:0], 1'b1);
          3'h2:    result_d[23:16] = lane(result_q[23:16], wdata_q[7:0], 1'b1);
          3'h3:    result_d[31:24] = lane(result_q[31:24], wdata_q[7:0], 1'b1);
          default: result_d[39:32] = lane(result_q[39:32], wdata_q[7:0], 1'b1);
        endcase
      end
    end
    // Automatic NCO capture uses the same selector.
    if (auto_en_q && nco_read_tick && prev_q == dfr_pkg::LOOP_NCO) begin
      result_d = sel_value;
    end
    case (rb_q)
      RB_IDLE: begin
        if (ctrl_q[dfr_pkg::SEM_BIT]) begin
          rb_d = RB_CAPTURE;
        end
      end
      RB_CAPTURE: begin
        result_d = sel_value;
        rb_d     = RB_CLEAR;
      end
      RB_CLEAR: begin
        // Then clear request.
        // A request written in this same cycle wins, so it is not lost.
        if (!sem_wr) begin
          ctrl_d[dfr_pkg::SEM_BIT] = 1'b0;
        end
        rb_d = RB_IDLE;
      end
      default: rb_d = RB_IDLE;
    endcase
    ctrl_d = ctrl_d & dfr_pkg::CONTROL_MASK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rb_q      <= RB_IDLE;
      ctrl_q    <= dfr_pkg::CONTROL_RESET;
      auto_en_q <= 1'b0;
      result_q  <= '0;
    end else begin
      rb_q      <= rb_d;
      ctrl_q    <= ctrl_d;
      auto_en_q <= auto_en_d;
      result_q  <= result_d;
    end
  end

  // ==========================================================================
  // AXI4-Lite channels
  // Address and data are caught separately, then answered one cycle after
  // both are held; reads answer one cycle after the address is taken.
  always_comb begin
    aw_d     = aw_q;
    w_d      = w_q;
    awidx_d  = awidx_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_awvalid && !aw_q) begin
      aw_d    = 1'b1;
      awidx_d = to_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && !w_q) begin
      w_d     = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_d     = 1'b0;
      w_d      = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = ((awidx_q >= dfr_pkg::RESULT_IDX0 &&
                   awidx_q <= dfr_pkg::CONTROL_IDX) ||
                  awidx_q == dfr_pkg::AUTO_CTRL_IDX)
                 ? dfr_pkg::AXI_OKAY : dfr_pkg::AXI_SLVERR;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = dfr_pkg::AXI_OKAY;
      rdata_d  = '0;
      case (to_idx(s_axi_araddr))
        12'h300: rdata_d[7:0] = result_q[7:0];
        12'h301: rdata_d[7:0] = result_q[15:8];
        12'h302: rdata_d[7:0] = result_q[23:16];
        12'h303: rdata_d[7:0] = result_q[31:24];
        12'h304: rdata_d[7:0] = result_q[39:32];
        dfr_pkg::CONTROL_IDX:   rdata_d[7:0] = ctrl_q & dfr_pkg::CONTROL_MASK;
        dfr_pkg::AUTO_CTRL_IDX: rdata_d[0]   = auto_en_q;
        dfr_pkg::STATUS_IDX:    rdata_d[3:0] = {rb_q, prev_q};
        default: rresp_d = dfr_pkg::AXI_SLVERR;
      endcase
    end
    // Ready flags are registered copies of each channel's free state.
    awrdy_d = !aw_d;
    wrdy_d  = !w_d;
    arrdy_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awidx_q  <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      bvalid_q <= 1'b0;
      bresp_q  <= dfr_pkg::AXI_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= dfr_pkg::AXI_OKAY;
      awrdy_q  <= 1'b1;
      wrdy_q   <= 1'b1;
      arrdy_q  <= 1'b1;
    end else begin
      aw_q     <= aw_d;
      w_q      <= w_d;
      awidx_q  <= awidx_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
      awrdy_q  <= awrdy_d;
      wrdy_q   <= wrdy_d;
      arrdy_q  <= arrdy_d;
    end
  end

  // ==========================================================================
  // Output assignments
  // Every output comes straight from a flip-flop.
  assign s_axi_awready     = awrdy_q;
  assign s_axi_wready      = wrdy_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arrdy_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rdata       = rdata_q;
  assign s_axi_rresp       = rresp_q;
  assign delta_freq_result = result_q;
  assign readback_busy     = ctrl_q[dfr_pkg::SEM_BIT];

endmodule

`default_nettype wire

// File: dfr_readback_asserts.sv
// Checker for the loop zero delta-frequency readback block.
// Assumes it is bound onto dfr_readback, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module dfr_readback_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Readback outputs
  input wire logic [39:0] delta_freq_result,
  input wire logic        readback_busy
);
  // ==========================================================================
  // Properties
  // All checks share the bus clock and are off while reset is low.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_busy_clears: assert property (
    $rose(readback_busy) |-> ##[1:4] !readback_busy)
    else $error("request bit not cleared in time");
  a_result_first: assert property (
    $fell(readback_busy) |-> $stable(delta_freq_result))
    else $error("result changed at the clearing edge");
  a_busy_cause: assert property (
    $rose(readback_busy) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
    else $error("request bit set without a host write");
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accepted");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule

bind dfr_readback dfr_readback_asserts dfr_readback_asserts_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .delta_freq_result(delta_freq_result),
  .readback_busy(readback_busy));

`default_nettype wire

// File: dfr_readback_test.sv
// Self-checking bench for the loop zero delta-frequency readback block.
// Assumes the package and design are compiled first; drives all ports.
`timescale 1ns/1ps
`default_nettype none

module dfr_readback_test;
  // ==========================================================================
  // Signals
  logic                aclk, aresetn, awvalid, wvalid, bready;
  logic                arvalid, rready, tick;
  logic [13:0]         awaddr, araddr;
  logic [31:0]         wdata, d;
  logic [3:0]          wstrb;
  logic                awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0]          bresp, rresp, r;
  logic [31:0]         rdata;
  logic [39:0]         res;
  dfr_pkg::dfr_loop_t  st;
  dfr_pkg::dfr_quant_t q, h, b;
  int                  err_total, n_checks;

  dfr_readback dfr_readback_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .loop_state(st),
    .loop_quant(q), .nco_read_tick(tick), .delta_freq_result(res),
    .readback_busy(busy));

  // ==========================================================================
  // Helpers
  // Compares one value and counts the comparison.
  task automatic chk(input string nm, input logic [39:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Writes one register word; bready rises after lag cycles and stays
  // high until bvalid is seen with it, when the response is taken.
  task automatic wr(input logic [11:0] idx, input logic [7:0] v,
                    input int lag = 0);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, v};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= (lag == 0);
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      done = bready && (bvalid === 1'b1);
      if (lag > 0) lag--;
      if (lag == 0 && !done) bready <= 1'b1;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  // Reads one register word into d and r; rready rises after lag cycles.
  task automatic rd(input logic [11:0] idx, input int lag = 0);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= (lag == 0);
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      done = rready && (rvalid === 1'b1);
      if (lag > 0) lag--;
      if (lag == 0 && !done) rready <= 1'b1;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Picks word n of a quantity set, integral first.
  function automatic logic [39:0] w(input dfr_pkg::dfr_quant_t x,
                                    input logic [1:0] n);
    w = x[159 - 40 * n -: 40];
  endfunction

  // Expected capture for a state, selector and entry history.
  function automatic logic [39:0] pick(input dfr_pkg::dfr_loop_t s_st,
    input logic [2:0] s, input logic fh, input dfr_pkg::dfr_quant_t lv, hd);
    if (s_st == dfr_pkg::LOOP_NORMAL) pick = w(lv, s[1:0]);
    else if (s_st == dfr_pkg::LOOP_NCO)
      pick = w(hd, (s == 3'h2 && fh) ? 2'h1 : s[1:0]);
    else pick = (s[2] && s != 3'h5) ? w(hd, s[1:0]) : w(lv, 2'h1);
  endfunction

  // Builds distinct quantities, some of them negative.
  function automatic dfr_pkg::dfr_quant_t mk(input logic [7:0] k);
    mk = {k, 32'h11, k, 32'h22, k, 32'h8000_0033, ~k, 32'hffff_ff44};
  endfunction

  // Requests a manual read, polls until done, compares the result.
  task automatic rb(input logic [2:0] s, input logic [39:0] e);
    logic [39:0] v;
    wr(dfr_pkg::CONTROL_IDX, {4'h1, 1'b0, s});
    d = 32'h10;
    while (d[4] !== 1'b0) rd(dfr_pkg::CONTROL_IDX);
    chk("control", {32'h0, d[7:0]}, {37'h0, s});
    for (int i = 0; i < 5; i++) begin
      rd(dfr_pkg::RESULT_IDX0 + 12'(i));
      v[8*i +: 8] = d[7:0];
    end
    chk("result", v, e);
    chk("result_port", res, e);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("mismatches %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  // Free-running 40 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    summarize();
  end

  // ==========================================================================
  // Tests
  // Resets, then walks registers and every selector in each state.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tick} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    st = dfr_pkg::LOOP_NORMAL;
    q = mk(8'h01);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(dfr_pkg::CONTROL_IDX);
    chk("ctrl_reset", {8'h0, d}, 40'h0);
    wr(dfr_pkg::CONTROL_IDX, 8'hef, 3);
    rd(dfr_pkg::CONTROL_IDX, 3);
    chk("ctrl_reserved", {8'h0, d}, 40'h07);
    chk("busy_idle", {39'h0, busy}, 40'h0);
    rd(12'h3ff);
    chk("bad_rd", {6'h0, r, d}, {6'h0, dfr_pkg::AXI_SLVERR, 32'h0});
    wr(12'h3ff, 8'h01);
    chk("bad_wr", {38'h0, r}, {38'h0, dfr_pkg::AXI_SLVERR});
    wr(dfr_pkg::RESULT_IDX0, 8'h5a);
    rd(dfr_pkg::RESULT_IDX0);
    chk("result_rw", {8'h0, d}, 40'h5a);
    for (int s = 0; s < 8; s++) rb(3'(s), w(q, 2'(s)));
    st <= dfr_pkg::LOOP_HOLDOVER;
    repeat (4) @(posedge aclk);
    q <= mk(8'h02);
    repeat (2) @(posedge aclk);
    rd(dfr_pkg::STATUS_IDX);
    chk("status", {8'h0, d}, {36'h0, 2'b00, dfr_pkg::LOOP_HOLDOVER});
    for (int s = 0; s < 8; s++)
      rb(3'(s), pick(st, 3'(s), 1'b0, q, mk(8'h01)));
    st <= dfr_pkg::LOOP_NCO;
    repeat (4) @(posedge aclk);
    q <= mk(8'h03);
    h = mk(8'h01);
    b = mk(8'h02);
    h.hold_filt = b.hold_filt;
    for (int s = 0; s < 8; s++)
      rb(3'(s), pick(st, 3'(s), 1'b1, q, h));
    wr(dfr_pkg::AUTO_CTRL_IDX, 8'h01);
    wr(dfr_pkg::CONTROL_IDX, 8'h00);
    tick <= 1'b1;
    @(posedge aclk);
    tick <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("auto", res, h.integ);
    wr(dfr_pkg::AUTO_CTRL_IDX, 8'h00);
    st <= dfr_pkg::LOOP_NORMAL;
    q <= mk(8'h04);
    repeat (4) @(posedge aclk);
    st <= dfr_pkg::LOOP_NCO;
    repeat (4) @(posedge aclk);
    q <= mk(8'h05);
    for (int s = 0; s < 8; s++)
      rb(3'(s), pick(st, 3'(s), 1'b0, q, mk(8'h04)));
    summarize();
  end
endmodule

`default_nettype wire
